/* rtl/tpio_ports.sv */
// Three 8-bit I/O ports with data-space registers and fixed drive types
`timescale 1ns/10ps
`default_nettype none
module tpio_ports
  import tpio_pkg::*;
#(
  parameter int LINES = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] core_addr,
  input wire logic core_wr,
  input wire logic core_rd,
  input wire logic [7:0] core_wdata,
  output logic [7:0] core_rdata,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pull_en,
  output logic [1:0] pa_strong_sink,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pull_en,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic [7:0] pc_pull_en,
  input wire logic spi_sclk,
  input wire logic spi_sda,
  input wire logic serial_enable_pin,
  output logic spi_sda_in,
  output logic spi_sclk_in,
  output logic power_event_input,
  output logic infrared_event_input
);
  typedef struct packed {
    logic [2:0][7:0] latch;
    logic [2:0][7:0] dir;
    logic [7:0] rd_data;
    logic [2:0][7:0] pin_out;
    logic [2:0][7:0] pin_oe;
    logic [2:0][7:0] pull_en;
    logic [1:0] strong_sink;
    logic sda_in;
    logic sclk_in;
    logic power_ev;
    logic ir_ev;
  } tpio_state_t;

  localparam tpio_state_t RST_STATE = '{
    latch: {RST_LATCH_C, RST_LATCH_B, RST_LATCH_A},
    dir: {RST_DIR_C, RST_DIR_B, RST_DIR_A},
    rd_data: 8'h00,
    pin_out: '0,
    pin_oe: '0,
    pull_en: RST_PULL_EN,
    strong_sink: 2'h0,
    sda_in: 1'b0,
    sclk_in: 1'b0,
    power_ev: 1'b0,
    ir_ev: 1'b0
  };

  tpio_state_t s;
  tpio_state_t next_s;
  logic [23:0] pin_sync_flat;
  logic [2:0][7:0] pin_sync;
  logic [2:0][7:0] line_out;
  logic [2:0][7:0] line_oe;
  logic [2:0][7:0] line_pull;
  logic [2:0][7:0] data_view;
  logic [7:0] spi_gate;

  if (LINES != 8)
  begin : g_bad_lines
    $error("tpio_ports supports exactly eight lines per port");
  end

  // High-voltage lines have no pull-up cell to switch on
  if (PULLUP_MASK[0][7:4] != 4'h0 || PULLUP_MASK[2][7:4] != 4'h0)
  begin : g_bad_masks
    $error("tpio_ports pull-up mask covers high-voltage lines");
  end

  tpio_sync #(
    .WIDTH(24)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({pc_in, pb_in, pa_in}),
    .sync_out(pin_sync_flat)
  );

  assign pin_sync = pin_sync_flat;

  // Serial signals gate the shared lines, others pass the data bit
  always_comb
  begin
    spi_gate = 8'hFF;
    spi_gate[SPI_CLK_LINE] = spi_sclk;
    spi_gate[SPI_DATA_LINE] = spi_sda;
    spi_gate[SPI_EN_LINE] = serial_enable_pin;
  end

  // One drive cell per line; drive type is fixed by the capability masks
  for (genvar p = 0; p < 3; p++)
  begin : g_port
    for (genvar b = 0; b < 8; b++)
    begin : g_line
      logic value;
      // Wired AND of serial signal and data bit on port C
      assign value = (p == 2) ? (s.latch[p][b] & spi_gate[b]) : s.latch[p][b];
      // Push-pull drives both levels; open-drain only pulls low
      assign line_out[p][b] = PUSH_PULL_MASK[p][b] ? value : 1'b0;
      assign line_oe[p][b] = PUSH_PULL_MASK[p][b] ? s.dir[p][b] : (s.dir[p][b] & ~value);
      // Pull-up only on capable input lines with data zero
      assign line_pull[p][b] = PULLUP_MASK[p][b] & ~s.dir[p][b] & ~s.latch[p][b];
      // Input lines read the pin, output lines the stored bit
      assign data_view[p][b] = s.dir[p][b] ? s.latch[p][b] : pin_sync[p][b];
    end
  end

  always_comb
  begin
    next_s = s;
    if (core_wr)
    begin
      unique case (core_addr)
        ADDR_DATA_A: next_s.latch[0] = core_wdata;
        ADDR_DATA_B: next_s.latch[1] = core_wdata;
        ADDR_DATA_C: next_s.latch[2] = core_wdata;
        ADDR_DIR_A: next_s.dir[0] = core_wdata;
        ADDR_DIR_B: next_s.dir[1] = core_wdata;
        ADDR_DIR_C: next_s.dir[2] = core_wdata;
        default: ;
      endcase
    end
    if (core_rd)
    begin
      unique case (core_addr)
        ADDR_DATA_A: next_s.rd_data = data_view[0];
        ADDR_DATA_B: next_s.rd_data = data_view[1];
        ADDR_DATA_C: next_s.rd_data = data_view[2];
        ADDR_DIR_A: next_s.rd_data = s.dir[0];
        ADDR_DIR_B: next_s.rd_data = s.dir[1];
        ADDR_DIR_C: next_s.rd_data = s.dir[2];
        default: next_s.rd_data = 8'h00;
      endcase
    end
    next_s.pin_out = line_out;
    next_s.pin_oe = line_oe;
    next_s.pull_en = line_pull;
    // High-current sink only while the LED lines pull low
    next_s.strong_sink = line_oe[0][7:6] & STRONG_SINK_MASK_A[7:6];
    next_s.sda_in = pin_sync[2][SPI_DATA_LINE];
    next_s.sclk_in = pin_sync[2][SPI_CLK_LINE];
    // Event latches see the pin even if software left it as output
    next_s.power_ev = pin_sync[2][POWER_LINE];
    next_s.ir_ev = pin_sync[2][INFRARED_LINE];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= RST_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign core_rdata = s.rd_data;
  assign pa_out = s.pin_out[0];
  assign pa_oe = s.pin_oe[0];
  assign pa_pull_en = s.pull_en[0];
  assign pa_strong_sink = s.strong_sink;
  assign pb_out = s.pin_out[1];
  assign pb_oe = s.pin_oe[1];
  assign pb_pull_en = s.pull_en[1];
  assign pc_out = s.pin_out[2];
  assign pc_oe = s.pin_oe[2];
  assign pc_pull_en = s.pull_en[2];
  assign spi_sda_in = s.sda_in;
  assign spi_sclk_in = s.sclk_in;
  assign power_event_input = s.power_ev;
  assign infrared_event_input = s.ir_ev;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  logic boot_done;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_done <= 1'b0;
    end
    else
    begin
      boot_done <= 1'b1;
    end
  end

  a_dir_drives_oe: assert property (pb_oe == $past(s.dir[1]))
    else $error("port B enable does not follow direction");
  a_pull_by_data: assert property (
    pb_pull_en == ($past(~s.dir[1]) & $past(~s.latch[1])))
    else $error("port B pull-up does not follow data bit");
  a_out_follows: assert property (
    pa_out[3:0] == $past(s.latch[0][3:0]))
    else $error("port A push-pull level differs from data");
  a_read_pins: assert property (
    core_rd && core_addr == ADDR_DATA_A |=> core_rdata == $past(data_view[0]))
    else $error("port A data read wrong");
  a_hv_no_drive: assert property (
    pa_out[7:4] == 4'h0 && pc_out == 8'h00)
    else $error("open-drain line drives high");
  a_hv_no_pull: assert property (
    pa_pull_en[7:4] == 4'h0 && pc_pull_en[7:4] == 4'h0)
    else $error("high-voltage line has pull-up");
  a_reset_vals: assert property (
    !boot_done |-> s.dir == {RST_DIR_C, RST_DIR_B, RST_DIR_A}
      && s.latch == {RST_LATCH_C, RST_LATCH_B, RST_LATCH_A})
    else $error("register reset values wrong");
  a_spi_wired: assert property (
    pc_oe[0] == ($past(s.dir[2][0]) & ~($past(s.latch[2][0]) & $past(spi_sclk))))
    else $error("serial clock line not wired AND");
  a_dir_write: assert property (
    core_wr && core_addr == ADDR_DIR_B |=> s.dir[1] == $past(core_wdata))
    else $error("direction write lost");
  a_no_pull_out: assert property (
    ##1 (pa_pull_en & $past(s.dir[0])) == 8'h00)
    else $error("pull-up on output line");
  a_led_sink: assert property (
    pa_strong_sink == $past(s.dir[0][7:6] & ~s.latch[0][7:6]))
    else $error("strong sink mismatch");

  // Drive types are fixed per line group
  a_pa_drive_en: assert property (
    pa_oe[3:0] == $past(s.dir[0][3:0]))
    else $error("port A push-pull enable wrong");
  a_pb_level: assert property (
    pb_out == $past(s.latch[1]))
    else $error("port B push-pull level wrong");
  a_pa_hv_enable: assert property (
    pa_oe[7:4] == $past(s.dir[0][7:4] & ~s.latch[0][7:4]))
    else $error("port A open-drain enable wrong");
  a_pc_hv_enable: assert property (
    pc_oe[7:4] == $past(s.dir[2][7:4] & ~s.latch[2][7:4]))
    else $error("port C open-drain enable wrong");
  a_pc_od_line: assert property (
    pc_oe[2] == $past(s.dir[2][2] & ~s.latch[2][2]))
    else $error("port C low line enable wrong");

  // Serial wired AND sits one flop behind the register; serial and event inputs one flop behind the synchroniser
  a_sda_wired: assert property (
    pc_oe[1] == ($past(s.dir[2][1]) & ~($past(s.latch[2][1]) & $past(spi_sda))))
    else $error("serial data line not wired AND");
  a_sen_wired: assert property (
    pc_oe[3] == ($past(s.dir[2][3]) & ~($past(s.latch[2][3]) & $past(serial_enable_pin))))
    else $error("serial enable line not wired AND");
  a_power_path: assert property (
    power_event_input == $past(pin_sync[2][POWER_LINE]))
    else $error("power event path wrong");
  a_ir_path: assert property (
    infrared_event_input == $past(pin_sync[2][INFRARED_LINE]))
    else $error("infrared event path wrong");
  a_sda_path: assert property (
    spi_sda_in == $past(pin_sync[2][SPI_DATA_LINE]))
    else $error("serial data input path wrong");
  a_sclk_path: assert property (
    spi_sclk_in == $past(pin_sync[2][SPI_CLK_LINE]))
    else $error("serial clock input path wrong");

  // Register access
  a_read_dir_c: assert property (
    core_rd && core_addr == ADDR_DIR_C |=> core_rdata == $past(s.dir[2]))
    else $error("port C direction read wrong");
  a_read_dir_a: assert property (
    core_rd && core_addr == ADDR_DIR_A |=> core_rdata == $past(s.dir[0]))
    else $error("port A direction read wrong");
  a_read_dir_b: assert property (
    core_rd && core_addr == ADDR_DIR_B |=> core_rdata == $past(s.dir[1]))
    else $error("port B direction read wrong");
  a_read_pc_pins: assert property (
    core_rd && core_addr == ADDR_DATA_C |=> core_rdata == $past(data_view[2]))
    else $error("port C data read wrong");
  a_read_pb_pins: assert property (
    core_rd && core_addr == ADDR_DATA_B |=> core_rdata == $past(data_view[1]))
    else $error("port B data read wrong");
  a_read_unmapped: assert property (
    core_rd && core_addr == 8'hC3 |=> core_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_latch_write_a: assert property (
    core_wr && core_addr == ADDR_DATA_A |=> s.latch[0] == $past(core_wdata))
    else $error("port A data write lost");
  a_latch_write_b: assert property (
    core_wr && core_addr == ADDR_DATA_B |=> s.latch[1] == $past(core_wdata))
    else $error("port B data write lost");
  a_latch_write_c: assert property (
    core_wr && core_addr == ADDR_DATA_C |=> s.latch[2] == $past(core_wdata))
    else $error("port C data write lost");
  a_dir_write_a: assert property (
    core_wr && core_addr == ADDR_DIR_A |=> s.dir[0] == $past(core_wdata))
    else $error("port A direction write lost");
  a_dir_write_c: assert property (
    core_wr && core_addr == ADDR_DIR_C |=> s.dir[2] == $past(core_wdata))
    else $error("port C direction write lost");
  a_write_ignored: assert property (
    core_wr && core_addr == 8'hC3 |=> s.latch == $past(s.latch)
      && s.dir == $past(s.dir))
    else $error("unmapped write changed a register");

  // Pull-ups and reset
  a_pc_pull_low: assert property (
    pc_pull_en[3:0] == $past(~s.dir[2][3:0] & ~s.latch[2][3:0]))
    else $error("port C pull-up does not follow data bit");
  a_pa_pull_low: assert property (
    pa_pull_en[3:0] == $past(~s.dir[0][3:0] & ~s.latch[0][3:0]))
    else $error("port A pull-up does not follow data bit");
  a_pb_no_pull_out: assert property (
    (pb_pull_en & $past(s.dir[1])) == 8'h00)
    else $error("pull-up on port B output line");
  a_pc_no_pull_out: assert property (
    (pc_pull_en & $past(s.dir[2])) == 8'h00)
    else $error("pull-up on port C output line");
  a_reset_outputs: assert property (
    !boot_done |-> pc_oe == 8'h00 && core_rdata == 8'h00 && pa_strong_sink == 2'h0)
    else $error("outputs wrong right after reset");

  c_dir_c_write: cover property (core_wr && core_addr == ADDR_DIR_C ##2 pc_oe != 8'h00);
  c_read_data_a: cover property (core_rd && core_addr == ADDR_DATA_A ##1 core_rdata != 8'h00);
  c_spi_low: cover property (pc_oe[SPI_DATA_LINE] && s.latch[2][SPI_DATA_LINE]);
  c_unmapped_read: cover property (core_rd && core_addr == 8'hC3);
  c_led_sink: cover property (pa_strong_sink == 2'h3);
endmodule
`default_nettype wire

/* rtl/tpio_pkg.sv */
// Constants of the three-port general purpose I/O block
// Functional notes
// - Each line has its own direction bit: 0 input, 1 output.
// - Input line: data bit 0 enables pull-up, 1 leaves it off.
// - Direction 1 makes the line output driving the stored data bit.
// - Data register read returns pin levels for lines in input mode.
// - Port A lines 0-3 and port B lines 0-7 drive push-pull.
// - Port A lines 4-7 and port C lines 4-7 are open-drain only.
// - High-voltage open-drain lines never get a pull-up.
// - Port C lines 0-3 are open-drain, never driving high.
// - Reset clears all registers except port C line 2: output, data one.
// - Serial-shared port C pin output is serial signal ANDed with data bit.
// - Port C: 0 serial clock, 1 data, 3 enable, 4 power, 6 infrared.
// - Six port registers read and write like data-space locations.
// - Bit n of data and direction registers controls line n.
// - Port A lines 6 and 7 sink more current for LED driving.
package tpio_pkg;
  localparam logic [7:0] ADDR_DATA_A = 8'hC0;
  localparam logic [7:0] ADDR_DATA_B = 8'hC1;
  localparam logic [7:0] ADDR_DATA_C = 8'hC2;
  localparam logic [7:0] ADDR_DIR_A = 8'hC4;
  localparam logic [7:0] ADDR_DIR_B = 8'hC5;
  localparam logic [7:0] ADDR_DIR_C = 8'hC6;
  localparam logic [7:0] RST_LATCH_A = 8'h00;
  localparam logic [7:0] RST_LATCH_B = 8'h00;
  localparam logic [7:0] RST_LATCH_C = 8'h04;
  localparam logic [7:0] RST_DIR_A = 8'h00;
  localparam logic [7:0] RST_DIR_B = 8'h00;
  localparam logic [7:0] RST_DIR_C = 8'h04;
  // Per-port line capabilities, index 0 = port A
  localparam logic [2:0][7:0] PUSH_PULL_MASK = {8'h00, 8'hFF, 8'h0F};
  localparam logic [2:0][7:0] PULLUP_MASK = {8'h0F, 8'hFF, 8'h0F};
  localparam logic [7:0] STRONG_SINK_MASK_A = 8'hC0;
  localparam int SPI_CLK_LINE = 0;
  localparam int SPI_DATA_LINE = 1;
  localparam int SPI_EN_LINE = 3;
  localparam int POWER_LINE = 4;
  localparam int INFRARED_LINE = 6;
  // Pull-up enables right after reset: pull-up-capable input lines with data zero
  localparam logic [2:0][7:0] RST_PULL_EN = {8'h0B, 8'hFF, 8'h0F};
  localparam int SYNC_STAGES = 2;
endpackage

/* rtl/tpio_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module tpio_sync
  import tpio_pkg::*;
#(
  parameter int WIDTH = 24
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } tpio_sync_state_t;

  tpio_sync_state_t s;
  tpio_sync_state_t next_s;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("tpio_sync width must be at least one");
  end

  // First stage feeds only the second one
  always_comb
  begin
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;
endmodule
`default_nettype wire

/* testbench/tpio_board.sv */
// Board-side model of the port pin wires
`timescale 1ns/10ps
`default_nettype none
module tpio_board
(
  input wire logic sys_clk,
  input wire logic [23:0] drv,
  input wire logic [23:0] oe,
  input wire logic [23:0] pull_en,
  input wire logic [23:0] ext,
  input wire logic [23:0] ext_en,
  output logic [23:0] pin
);
  logic [23:0] noise = 24'h5A5A5A;
  // Floating lines wander, so no read can lean on a stale level
  always @(posedge sys_clk) noise <= ~noise;
  // Driver wins, then board, then pull-up
  assign pin = (oe & drv) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull_en | noise));
endmodule
`default_nettype wire

/* testbench/tb_tpio_ports.sv */
// Self-checking bench for the three-port I/O block
`timescale 1ns/10ps
`default_nettype none
module tb_tpio_ports
  import tpio_pkg::*;
;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic [7:0] core_addr = 0;
  logic [7:0] core_wdata = 0;
  logic core_wr = 0;
  logic core_rd = 0;
  logic rd_d = 0;
  logic spi_sclk = 1;
  logic spi_sda = 1;
  logic serial_enable_pin = 1;
  logic [23:0] ext = 0;
  logic [23:0] ext_en = '1;
  wire logic [23:0] pin, drv, oe, pull;
  logic [7:0] core_rdata;
  logic [1:0] sink;
  logic sda_in, sclk_in, pwr_ev, ir_ev;
  int fails = 0;
  int n_checks = 0;
  logic [15:0] exp_q[$];
  logic [7:0] dir[3];
  logic [7:0] lat[3];

  tpio_ports dut (.sys_clk(sys_clk), .rst_b(rst_b), .core_addr(core_addr),
    .core_wr(core_wr), .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
    .pa_in(pin[7:0]), .pa_out(drv[7:0]), .pa_oe(oe[7:0]), .pa_pull_en(pull[7:0]),
    .pa_strong_sink(sink), .pb_in(pin[15:8]), .pb_out(drv[15:8]), .pb_oe(oe[15:8]),
    .pb_pull_en(pull[15:8]), .pc_in(pin[23:16]), .pc_out(drv[23:16]), .pc_oe(oe[23:16]),
    .pc_pull_en(pull[23:16]), .spi_sclk(spi_sclk), .spi_sda(spi_sda),
    .serial_enable_pin(serial_enable_pin), .spi_sda_in(sda_in), .spi_sclk_in(sclk_in),
    .power_event_input(pwr_ev), .infrared_event_input(ir_ev));
  tpio_board board (.sys_clk(sys_clk), .drv(drv), .oe(oe), .pull_en(pull), .ext(ext),
    .ext_en(ext_en), .pin(pin));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole-byte writes only, never read-modify-write of a data register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_addr = a;
    core_wdata = d;
    core_wr = 1;
    @(negedge sys_clk);
    core_wr = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    core_addr = a;
    core_rd = 1;
    exp_q.push_back({m, e});
    @(negedge sys_clk);
    core_rd = 0;
  endtask

  // Read data lands one cycle after the strobe
  always @(posedge sys_clk) rd_d <= core_rd;
  always @(negedge sys_clk)
    if (rd_d && exp_q.size() > 0)
    begin
      check(core_rdata & exp_q[0][15:8], exp_q[0][7:0], "read");
      void'(exp_q.pop_front());
    end

  // Returns {oe, out, pull_en, read view} of one port
  function automatic logic [31:0] model(input int p, input logic [7:0] d,
    input logic [7:0] l, input logic [7:0] e);
    logic [7:0] v;
    v = l;
    if (p == 2)
      v = v & {4'hF, serial_enable_pin, 1'h1, spi_sda, spi_sclk};
    // Push-pull level shows the stored bit even while the line is input
    return {d & (PUSH_PULL_MASK[p] | ~v), PUSH_PULL_MASK[p] & v,
      ~d & ~l & PULLUP_MASK[p], (d & l) | (~d & e)};
  endfunction

  task automatic ports(input logic [23:0] e, input logic [23:0] mk);
    logic [31:0] m;
    for (int p = 0; p < 3; p++)
    begin
      m = model(p, dir[p], lat[p], e[8*p +: 8]);
      check(oe[8*p +: 8], m[31:24], "oe");
      check(drv[8*p +: 8], m[23:16], "out");
      check(pull[8*p +: 8], m[15:8], "pull_en");
      rd(ADDR_DATA_A + p[7:0], m[7:0] & mk[8*p +: 8], mk[8*p +: 8]);
      rd(ADDR_DIR_A + p[7:0], dir[p], 8'hFF);
    end
    m = model(0, dir[0], lat[0], e[7:0]);
    check({6'h00, sink}, {6'h00, m[31:30]}, "sink");
    m = model(2, dir[2], lat[2], e[23:16]);
    if (&mk)
      check({4'h0, ir_ev, pwr_ev, sda_in, sclk_in}, {4'h0, ~m[30] & e[22],
        ~m[28] & e[20], ~m[25] & e[17], ~m[24] & e[16]}, "pc inputs");
  endtask

  task automatic setup(input logic [23:0] e, input logic [23:0] mk);
    ext = e;
    for (int p = 0; p < 3; p++)
    begin
      wr(ADDR_DATA_A + p[7:0], lat[p]);
      wr(ADDR_DIR_A + p[7:0], dir[p]);
    end
    // Two sync flops, register and pin flop all settle
    repeat (5) @(negedge sys_clk);
    ports(e, mk);
  endtask

  initial
  begin
    void'($urandom(77));
    repeat (6) @(negedge sys_clk);
    rst_b = 1;
    ext = 24'hA5C396;
    dir = '{8'h00, 8'h00, 8'h04};
    lat = '{8'h00, 8'h00, 8'h04};
    repeat (4) @(negedge sys_clk);
    ports(ext, '1);
    $display("test reset done");
    // Floating board, only pulled lines are known
    ext_en = '0;
    dir = '{8'h00, 8'h00, 8'h00};
    lat = '{8'h00, 8'h00, 8'h00};
    setup('1, {PULLUP_MASK[2], PULLUP_MASK[1], PULLUP_MASK[0]});
    ext_en = '1;
    $display("test pull-ups done");
    for (int s = 0; s < 8; s++)
    begin
      {spi_sclk, spi_sda, serial_enable_pin} = 3'(s);
      dir[2] = 8'h0B;
      lat[2] = 8'h0B;
      setup(24'($urandom), '1);
    end
    $display("test serial lines done");
    repeat (12)
    begin
      for (int p = 0; p < 3; p++)
      begin
        dir[p] = 8'($urandom);
        lat[p] = 8'($urandom);
      end
      {spi_sclk, spi_sda, serial_enable_pin} = 3'($urandom);
      setup(24'($urandom), '1);
    end
    $display("test random modes done");
    wr(8'hC3, 8'hFF);
    wr(8'hC7, 8'hFF);
    rd(8'hC3, 8'h00, 8'hFF);
    repeat (5) @(negedge sys_clk);
    ports(ext, '1);
    $display("test unmapped done");
    repeat (3) @(negedge sys_clk);
    give_verdict();
  end

  initial
  begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
